// [hw/sesr_top.sv]
// Function
// [R1] baseband summary drives bit 10 of the operation condition word.
// [R2] baseband condition bit 0 follows baseband generator active.
// [R3] baseband condition bit 1 follows baseband data input/output activity.
// [R4] baseband condition bits 2 to 15 read zero.
// [R5] condition words track live status; host writes to them are ignored.
// [R6] condition reads return the plain binary sum of set bits.
// [R7] rise filter enables 0-to-1 latching, fall filter 1-to-0 latching.
// [R8] host writes each filter or mask as one summed value.
// [R9] event bits set on enabled transitions and stay set.
// [R10] reading an event register returns it, then clears it.
// [R11] baseband mask selects events feeding the baseband summary.
// [R12] mask reads return the value last written.
// [R13] questionable summary drives status byte bit 3.
// [R14] questionable bits 0,1,2,6,10,11,13,14,15 read zero.
// [R15] questionable bit 3 mirrors the power group summary.
// [R16] questionable bit 4 is high while the heater or oven is cold.
// [R17] questionable bit 5 mirrors the frequency group summary.
// [R18] questionable bit 7 mirrors the modulation group summary.
// [R19] questionable bit 8 mirrors the calibration group summary.
// [R20] questionable bit 9 holds self-test failure until power cycle only.
// [R21] questionable bit 12 mirrors the bit error tester summary.
// [R22] questionable mask selects events feeding the status byte bit 3.
// [R23] summaries are the or of events anded with masks, every cycle.
// [R24] filters, events and masks are zero after reset.
module sesr_top #(
   parameter int unsigned WIDTH = 16
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // baseband generator status
   input wire logic bb_active,
   input wire logic bb_data_io,
   // questionable status sources
   input wire sesr_pkg::sesr_quest_src_type quest_src,
   input wire logic selftest_fail,
   // clear-status command pulse
   input wire logic clear_status_command,
   // host register port
   input wire sesr_pkg::sesr_req_type host_req,
   output sesr_pkg::sesr_rsp_type host_rsp_q,
   // summaries towards the parent registers
   output logic oper_bb_summary_q,
   output logic stb_quest_summary_q
);

   // sampled conditions
   logic [WIDTH-1:0] bb_cond_q;
   logic [WIDTH-1:0] q_cond_q;
   logic [WIDTH-1:0] bb_cond_d;
   logic [WIDTH-1:0] q_cond_d;
   logic selftest_held;

   // host decode
   logic is_rd;
   logic is_wr;
   logic wr_bb_rise;
   logic wr_bb_fall;
   logic wr_bb_mask;
   logic wr_q_rise;
   logic wr_q_fall;
   logic wr_q_mask;
   logic rd_bb_event;
   logic rd_q_event;

   // group contents
   logic [WIDTH-1:0] bb_rise_q;
   logic [WIDTH-1:0] bb_fall_q;
   logic [WIDTH-1:0] bb_event_q;
   logic [WIDTH-1:0] bb_mask_q;
   logic bb_summary;
   logic [WIDTH-1:0] q_rise_q;
   logic [WIDTH-1:0] q_fall_q;
   logic [WIDTH-1:0] q_event_q;
   logic [WIDTH-1:0] q_mask_q;
   logic q_summary;

   // read path
   logic [WIDTH-1:0] rd_mux;
   sesr_pkg::sesr_rsp_type host_rsp_d;

   // select match helper, shared by every select decode line
   function automatic logic sel_is(input logic [3:0] sel, input logic [3:0] code);
      sel_is = (sel == code);
   endfunction

   // place one status level at its condition position
   function automatic logic [WIDTH-1:0] put_bit(input logic val, input int unsigned pos);
      logic [WIDTH-1:0] w;
      w = '0;
      w[pos] = val;
      put_bit = w;
   endfunction

   // baseband condition word: only the two live flags, the rest zero
   assign bb_cond_d = put_bit(bb_active, sesr_pkg::BB_ACTIVE_BIT) // [R2]
      | put_bit(bb_data_io, sesr_pkg::BB_DATA_IO_BIT); // [R3] [R4]

   // questionable condition word built from subordinate summaries
   assign q_cond_d = put_bit(quest_src.power_summary, sesr_pkg::Q_POWER_BIT) // [R15]
      | put_bit(quest_src.cold_detect, sesr_pkg::Q_COLD_BIT) // [R16]
      | put_bit(quest_src.freq_summary, sesr_pkg::Q_FREQ_BIT) // [R17]
      | put_bit(quest_src.mod_summary, sesr_pkg::Q_MOD_BIT) // [R18]
      | put_bit(quest_src.cal_summary, sesr_pkg::Q_CAL_BIT) // [R19]
      | put_bit(selftest_held, sesr_pkg::Q_SELFTEST_BIT) // [R20]
      | put_bit(quest_src.bit_error_tester_summary, sesr_pkg::Q_BIT_ERROR_TESTER_BIT); // [R21] [R14]

   // condition words sample live status and have no write path at all
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         bb_cond_q <= '0;
         q_cond_q <= '0;
      end else begin
         bb_cond_q <= bb_cond_d; // [R5]
         q_cond_q <= q_cond_d; // [R5]
      end
   end

   // self-test failure stays until power-on reset, immune to clear-status
   sesr_sticky u_selftest (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .fail_in(selftest_fail),
      .fail_q(selftest_held) // [R20]
   );

   // request decode; condition selects have no write strobe on purpose
   assign is_rd = host_req.valid && !host_req.write;
   assign is_wr = host_req.valid && host_req.write;
   // host sends each filter or mask as one summed word, stored as is
   assign wr_bb_rise = is_wr && sel_is(host_req.sel, sesr_pkg::SEL_BB_RISE); // [R8]
   assign wr_bb_fall = is_wr && sel_is(host_req.sel, sesr_pkg::SEL_BB_FALL); // [R8]
   assign wr_bb_mask = is_wr && sel_is(host_req.sel, sesr_pkg::SEL_BB_MASK); // [R8]
   assign wr_q_rise = is_wr && sel_is(host_req.sel, sesr_pkg::SEL_Q_RISE);
   assign wr_q_fall = is_wr && sel_is(host_req.sel, sesr_pkg::SEL_Q_FALL);
   assign wr_q_mask = is_wr && sel_is(host_req.sel, sesr_pkg::SEL_Q_MASK);
   assign rd_bb_event = is_rd && sel_is(host_req.sel, sesr_pkg::SEL_BB_EVENT); // [R10]
   assign rd_q_event = is_rd && sel_is(host_req.sel, sesr_pkg::SEL_Q_EVENT); // [R10]

   // baseband operation group
   sesr_group #(
      .WIDTH(WIDTH)
   ) u_bb_group (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .cond(bb_cond_q),
      .wr_rise(wr_bb_rise),
      .wr_fall(wr_bb_fall),
      .wr_mask(wr_bb_mask),
      .wdata(host_req.wdata[WIDTH-1:0]),
      .rd_event(rd_bb_event),
      .clr_status(clear_status_command),
      .rise_filter_q(bb_rise_q),
      .fall_filter_q(bb_fall_q),
      .event_q(bb_event_q),
      .mask_q(bb_mask_q),
      .summary(bb_summary) // [R11]
   );

   // questionable data group
   sesr_group #(
      .WIDTH(WIDTH)
   ) u_q_group (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .cond(q_cond_q),
      .wr_rise(wr_q_rise),
      .wr_fall(wr_q_fall),
      .wr_mask(wr_q_mask),
      .wdata(host_req.wdata[WIDTH-1:0]),
      .rd_event(rd_q_event),
      .clr_status(clear_status_command),
      .rise_filter_q(q_rise_q),
      .fall_filter_q(q_fall_q),
      .event_q(q_event_q),
      .mask_q(q_mask_q),
      .summary(q_summary) // [R22]
   );

   // read mux; the value is the binary weight sum the host prints in decimal
   always_comb begin
      unique case (host_req.sel)
         sesr_pkg::SEL_BB_COND: rd_mux = bb_cond_q; // [R6]
         sesr_pkg::SEL_BB_FALL: rd_mux = bb_fall_q;
         sesr_pkg::SEL_BB_RISE: rd_mux = bb_rise_q;
         sesr_pkg::SEL_BB_EVENT: rd_mux = bb_event_q; // [R10]
         sesr_pkg::SEL_BB_MASK: rd_mux = bb_mask_q; // [R12]
         sesr_pkg::SEL_Q_COND: rd_mux = q_cond_q; // [R6]
         sesr_pkg::SEL_Q_FALL: rd_mux = q_fall_q;
         sesr_pkg::SEL_Q_RISE: rd_mux = q_rise_q;
         sesr_pkg::SEL_Q_EVENT: rd_mux = q_event_q; // [R10]
         sesr_pkg::SEL_Q_MASK: rd_mux = q_mask_q; // [R12]
         default: rd_mux = WIDTH'(sesr_pkg::UNMAPPED_READ);
      endcase
   end

   // answer every request; writes echo zero data
   assign host_rsp_d = '{valid: host_req.valid, rdata: (is_rd ? 16'(rd_mux) : 16'h0000)};

   // registered answer: the event value is the one before its clear
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         host_rsp_q <= '0;
      end else begin
         host_rsp_q <= host_rsp_d;
      end
   end

   // summaries registered so the outputs come from flip-flops
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         oper_bb_summary_q <= 1'b0;
         stb_quest_summary_q <= 1'b0;
      end else begin
         oper_bb_summary_q <= bb_summary; // [R1] [R23]
         stb_quest_summary_q <= q_summary; // [R13] [R23]
      end
   end

endmodule

// [hw/sesr_pkg.sv]
package sesr_pkg;

   // register word width of every status register
   localparam int unsigned REG_W = 16;
   localparam int unsigned SEL_W = 4;

   // host select codes for the register port
   localparam logic [3:0] SEL_BB_COND = 4'h0;
   localparam logic [3:0] SEL_BB_FALL = 4'h1;
   localparam logic [3:0] SEL_BB_RISE = 4'h2;
   localparam logic [3:0] SEL_BB_EVENT = 4'h3;
   localparam logic [3:0] SEL_BB_MASK = 4'h4;
   localparam logic [3:0] SEL_Q_COND = 4'h5;
   localparam logic [3:0] SEL_Q_FALL = 4'h6;
   localparam logic [3:0] SEL_Q_RISE = 4'h7;
   localparam logic [3:0] SEL_Q_EVENT = 4'h8;
   localparam logic [3:0] SEL_Q_MASK = 4'h9;

   // baseband condition bit positions
   localparam int unsigned BB_ACTIVE_BIT = 0;
   localparam int unsigned BB_DATA_IO_BIT = 1;

   // questionable condition bit positions
   localparam int unsigned Q_POWER_BIT = 3;
   localparam int unsigned Q_COLD_BIT = 4;
   localparam int unsigned Q_FREQ_BIT = 5;
   localparam int unsigned Q_MOD_BIT = 7;
   localparam int unsigned Q_CAL_BIT = 8;
   localparam int unsigned Q_SELFTEST_BIT = 9;
   localparam int unsigned Q_BIT_ERROR_TESTER_BIT = 12;

   // positions in the parent registers fed by the summaries
   localparam int unsigned OPER_BB_SUMMARY_BIT = 10;
   localparam int unsigned STB_OPER_SUMMARY_BIT = 7;
   localparam int unsigned STB_QUEST_SUMMARY_BIT = 3;

   // reset values of filters, events and masks, and the unmapped read value
   localparam logic [15:0] FILTER_RESET = 16'h0000;
   localparam logic [15:0] EVENT_RESET = 16'h0000;
   localparam logic [15:0] MASK_RESET = 16'h0000;
   localparam logic [15:0] UNMAPPED_READ = 16'h0000;

   // one host access to the status registers
   typedef struct packed {
      logic valid;
      logic write;
      logic [3:0] sel;
      logic [15:0] wdata;
   } sesr_req_type;

   // answer to one host access
   typedef struct packed {
      logic valid;
      logic [15:0] rdata;
   } sesr_rsp_type;

   // live hardware status feeding the questionable condition
   typedef struct packed {
      logic power_summary;
      logic cold_detect;
      logic freq_summary;
      logic mod_summary;
      logic cal_summary;
      logic bit_error_tester_summary;
   } sesr_quest_src_type;

endpackage

// [hw/sesr_sticky.sv]
// holds a self-test failure until the next power-on reset
module sesr_sticky (
   // clock and power-on reset
   input wire logic core_clk,
   input wire logic rst_n,
   // failure report from the power-up self-test
   input wire logic fail_in,
   // held failure flag
   output logic fail_q
);

   // no software clear exists on purpose: only a power cycle ends it
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         fail_q <= 1'b0;
      end else if (fail_in) begin
         fail_q <= 1'b1;
      end
   end

endmodule

// [hw/sesr_group.sv]
// one status group: transition filters, event latch, enable mask, summary
module sesr_group #(
   parameter int unsigned WIDTH = 16
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // live condition word
   input wire logic [WIDTH-1:0] cond,
   // host writes
   input wire logic wr_rise,
   input wire logic wr_fall,
   input wire logic wr_mask,
   input wire logic [WIDTH-1:0] wdata,
   // destructive read and clear-status pulse
   input wire logic rd_event,
   input wire logic clr_status,
   // register contents
   output logic [WIDTH-1:0] rise_filter_q,
   output logic [WIDTH-1:0] fall_filter_q,
   output logic [WIDTH-1:0] event_q,
   output logic [WIDTH-1:0] mask_q,
   // or of enabled events
   output logic summary
);

   logic [WIDTH-1:0] prev_q;
   logic [WIDTH-1:0] rise_hit;
   logic [WIDTH-1:0] fall_hit;
   logic [WIDTH-1:0] clr_bits;
   logic [WIDTH-1:0] event_d;

   // qualified edges of the condition word
   assign rise_hit = cond & ~prev_q & rise_filter_q; // [R7]
   assign fall_hit = ~cond & prev_q & fall_filter_q; // [R7]
   assign clr_bits = (rd_event || clr_status) ? '1 : '0; // [R10]
   // a new edge wins over a clear in the same cycle, so no event is lost
   assign event_d = (event_q & ~clr_bits) | rise_hit | fall_hit; // [R9]
   assign summary = |(event_q & mask_q); // [R23]

   // previous condition for edge detection
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         prev_q <= '0;
      end else begin
         prev_q <= cond;
      end
   end

   // filters and mask hold the host's last written value
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         rise_filter_q <= WIDTH'(sesr_pkg::FILTER_RESET); // [R24]
         fall_filter_q <= WIDTH'(sesr_pkg::FILTER_RESET); // [R24]
         mask_q <= WIDTH'(sesr_pkg::MASK_RESET); // [R24]
      end else begin
         if (wr_rise) begin
            rise_filter_q <= wdata;
         end
         if (wr_fall) begin
            fall_filter_q <= wdata;
         end
         if (wr_mask) begin
            mask_q <= wdata; // [R12]
         end
      end
   end

   // event latch
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         event_q <= WIDTH'(sesr_pkg::EVENT_RESET); // [R24]
      end else begin
         event_q <= event_d;
      end
   end

endmodule

// [tb/sesr_top_asserts.sv]
module sesr_asserts #(
   parameter int unsigned WIDTH = 16
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // live status
   input wire logic bb_active,
   input wire logic bb_data_io,
   input wire sesr_pkg::sesr_quest_src_type quest_src,
   input wire logic selftest_fail,
   input wire logic clear_status_command,
   // host port
   input wire sesr_pkg::sesr_req_type host_req,
   input wire sesr_pkg::sesr_rsp_type host_rsp_q,
   // summaries
   input wire logic oper_bb_summary_q,
   input wire logic stb_quest_summary_q
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // decoded accesses; a mask write may also drop a summary
   wire rd_go = host_req.valid && !host_req.write;
   wire wr_go = host_req.valid && host_req.write;
   wire [3:0] sel = host_req.sel;
   wire bb_clr = clear_status_command || (rd_go && sel == sesr_pkg::SEL_BB_EVENT)
      || (wr_go && sel == sesr_pkg::SEL_BB_MASK);
   wire q_clr = clear_status_command || (rd_go && sel == sesr_pkg::SEL_Q_EVENT)
      || (wr_go && sel == sesr_pkg::SEL_Q_MASK);
   // live questionable word, sticky bit 9 left out
   wire [15:0] q_live = {3'h0, quest_src.bit_error_tester_summary, 3'h0, quest_src.cal_summary,
      quest_src.mod_summary, 1'b0, quest_src.freq_summary, quest_src.cold_detect,
      quest_src.power_summary, 3'h0};
   // failure seen since reset; the age lets the sticky bit settle
   logic fail_seen_q;
   logic [1:0] fail_age_q;
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         fail_seen_q <= 1'b0;
         fail_age_q <= 2'h0;
      end else begin
         fail_seen_q <= fail_seen_q | selftest_fail;
         fail_age_q <= (fail_seen_q && fail_age_q != 2'h3) ? fail_age_q + 2'h1 : fail_age_q;
      end
   end
   chk_rsp_follows: assert property (host_req.valid |=> host_rsp_q.valid)
      else $error("request not answered next cycle");
   chk_rsp_idle: assert property (!host_req.valid |=> !host_rsp_q.valid)
      else $error("answer without request");
   chk_bb_cond_read: assert property (rd_go && sel == sesr_pkg::SEL_BB_COND |=>
      host_rsp_q.rdata == {14'h0000, $past(bb_data_io, 2), $past(bb_active, 2)})
      else $error("baseband condition read wrong");
   chk_q_cond_read: assert property (
      rd_go && sel == sesr_pkg::SEL_Q_COND |=> (host_rsp_q.rdata & 16'hfdff) == $past(q_live, 2))
      else $error("questionable condition read wrong");
   chk_selftest_held: assert property (rd_go && sel == sesr_pkg::SEL_Q_COND
      && fail_age_q == 2'h3 |=> host_rsp_q.rdata[9])
      else $error("self-test bit lost");
   chk_selftest_clear: assert property (rd_go && sel == sesr_pkg::SEL_Q_COND
      && !fail_seen_q |=> !host_rsp_q.rdata[9])
      else $error("self-test bit without failure");
   chk_write_zero: assert property (wr_go |=> host_rsp_q.rdata == 16'h0000)
      else $error("write answer not zero");
   chk_unmapped_zero: assert property (
      rd_go && sel > 4'h9 |=> host_rsp_q.rdata == 16'h0000)
      else $error("unmapped read not zero");
   // a clear empties the latch at one edge, the registered summary drops one edge later
   chk_bb_sum_hold: assert property ($fell(oper_bb_summary_q) |-> $past(bb_clr, 2))
      else $error("baseband summary dropped without clear");
   chk_q_sum_hold: assert property ($fell(stb_quest_summary_q) |-> $past(q_clr, 2))
      else $error("questionable summary dropped without clear");
   cover property ($rose(oper_bb_summary_q));
   cover property ($rose(stb_quest_summary_q));
   cover property (rd_go && sel == sesr_pkg::SEL_Q_COND && fail_age_q == 2'h3);
endmodule
bind sesr_top sesr_asserts #(.WIDTH(WIDTH)) i_chk (.core_clk(core_clk), .rst_n(rst_n),
   .bb_active(bb_active), .bb_data_io(bb_data_io), .quest_src(quest_src),
   .selftest_fail(selftest_fail), .clear_status_command(clear_status_command),
   .host_req(host_req), .host_rsp_q(host_rsp_q), .oper_bb_summary_q(oper_bb_summary_q),
   .stb_quest_summary_q(stb_quest_summary_q));

// [tb/sesr_host.sv]
module sesr_host (
   // clock
   input wire logic core_clk,
   // register port towards the device
   output sesr_pkg::sesr_req_type host_req,
   input wire sesr_pkg::sesr_rsp_type host_rsp_q
);
   timeunit 1ns;
   timeprecision 1ns;
   initial host_req = '0;
   // one access; a filter or mask goes over as one summed word
   task automatic access(input logic wr, input logic [3:0] sel, input logic [15:0] wd,
      output logic [15:0] rd);
      @(posedge core_clk);
      #1;
      host_req = '{valid: 1'b1, write: wr, sel: sel, wdata: wd};
      @(posedge core_clk);
      #1;
      // released fields carry the inverse so stale values never look valid
      host_req = '{valid: 1'b0, write: ~wr, sel: ~sel, wdata: ~wd};
      rd = (host_rsp_q.valid === 1'b1) ? host_rsp_q.rdata : 16'hxxxx;
   endtask
endmodule

// [tb/status_event_reporting_tb_top.sv]
module status_event_reporting_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk, rst_n, bb_active, bb_data_io, selftest_fail, clear_status_command;
   logic oper_bb_summary_q, stb_quest_summary_q;
   sesr_pkg::sesr_quest_src_type quest_src;
   sesr_pkg::sesr_req_type host_req;
   sesr_pkg::sesr_rsp_type host_rsp_q;
   int err_total = 0;
   int compares = 0;
   sesr_top #(.WIDTH(16)) i_dut (.core_clk(core_clk), .rst_n(rst_n), .bb_active(bb_active),
      .bb_data_io(bb_data_io), .quest_src(quest_src), .selftest_fail(selftest_fail),
      .clear_status_command(clear_status_command), .host_req(host_req),
      .host_rsp_q(host_rsp_q), .oper_bb_summary_q(oper_bb_summary_q),
      .stb_quest_summary_q(stb_quest_summary_q));
   sesr_host i_host (.core_clk(core_clk), .host_req(host_req), .host_rsp_q(host_rsp_q));
   // 10 MHz clock
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // every drive lands one time unit after an edge
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic rd(input logic [3:0] sel, input logic [15:0] exp);
      logic [15:0] v;
      i_host.access(1'b0, sel, 16'h0000, v);
      chk($sformatf("register %0d", sel), v, exp);
   endtask
   task automatic wr(input logic [3:0] sel, input logic [15:0] d);
      logic [15:0] v;
      i_host.access(1'b1, sel, d, v);
   endtask
   task automatic do_reset;
      rst_n = 1'b0;
      cyc(6);
      rst_n = 1'b1;
   endtask
   task automatic t_reset;
      for (int s = 0; s < 12; s++) rd(4'(s), 16'h0000);
   endtask
   task automatic t_bb_cond;
      bb_active = 1'b1;
      cyc(1);
      rd(sesr_pkg::SEL_BB_COND, 16'h0001);
      bb_data_io = 1'b1;
      wr(sesr_pkg::SEL_BB_COND, 16'hfff0);
      rd(sesr_pkg::SEL_BB_COND, 16'h0003);
      bb_active = 1'b0;
      cyc(1);
      rd(sesr_pkg::SEL_BB_COND, 16'h0002);
   endtask
   // only the enabled direction of each bit may latch
   task automatic t_events;
      wr(sesr_pkg::SEL_BB_RISE, 16'h0001);
      wr(sesr_pkg::SEL_BB_FALL, 16'h0002);
      rd(sesr_pkg::SEL_BB_RISE, 16'h0001);
      rd(sesr_pkg::SEL_BB_FALL, 16'h0002);
      bb_data_io = 1'b0;
      cyc(1);
      bb_active = 1'b1;
      cyc(1);
      bb_active = 1'b0;
      cyc(3);
      rd(sesr_pkg::SEL_BB_EVENT, 16'h0003);
      rd(sesr_pkg::SEL_BB_EVENT, 16'h0000);
   endtask
   task automatic t_summary;
      wr(sesr_pkg::SEL_BB_MASK, 16'h0002);
      rd(sesr_pkg::SEL_BB_MASK, 16'h0002);
      bb_data_io = 1'b1;
      cyc(1);
      bb_data_io = 1'b0;
      cyc(4);
      chk("bb summary", {15'h0000, oper_bb_summary_q}, 16'h0001);
      rd(sesr_pkg::SEL_BB_EVENT, 16'h0002);
      cyc(2);
      chk("bb summary", {15'h0000, oper_bb_summary_q}, 16'h0000);
      bb_active = 1'b1;
      cyc(1);
      bb_active = 1'b0;
      cyc(4);
      chk("bb summary", {15'h0000, oper_bb_summary_q}, 16'h0000);
      rd(sesr_pkg::SEL_BB_EVENT, 16'h0001);
   endtask
   // sticky self-test bit survives clear-status but not a reset
   task automatic t_quest;
      quest_src = '1;
      wr(sesr_pkg::SEL_Q_RISE, 16'h0200);
      wr(sesr_pkg::SEL_Q_MASK, 16'h0200);
      wr(sesr_pkg::SEL_Q_FALL, 16'h1000);
      rd(sesr_pkg::SEL_Q_FALL, 16'h1000);
      rd(sesr_pkg::SEL_Q_COND, 16'h11b8);
      selftest_fail = 1'b1;
      cyc(1);
      selftest_fail = 1'b0;
      cyc(4);
      chk("quest summary", {15'h0000, stb_quest_summary_q}, 16'h0001);
      clear_status_command = 1'b1;
      cyc(1);
      clear_status_command = 1'b0;
      cyc(2);
      chk("quest summary", {15'h0000, stb_quest_summary_q}, 16'h0000);
      rd(sesr_pkg::SEL_Q_COND, 16'h13b8);
      // bit 12 falls with only its fall filter set; the mask keeps it off the summary
      quest_src.bit_error_tester_summary = 1'b0;
      cyc(1);
      rd(sesr_pkg::SEL_Q_EVENT, 16'h1000);
      rd(sesr_pkg::SEL_Q_EVENT, 16'h0000);
      quest_src.bit_error_tester_summary = 1'b1;
      do_reset;
      cyc(2);
      rd(sesr_pkg::SEL_Q_COND, 16'h11b8);
      rd(sesr_pkg::SEL_Q_MASK, 16'h0000);
   endtask
   task automatic print_verdict;
      if (err_total == 0 && compares > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial begin
      rst_n = 1'b0;
      bb_active = 1'b0;
      bb_data_io = 1'b0;
      quest_src = '0;
      selftest_fail = 1'b0;
      clear_status_command = 1'b0;
      do_reset;
      t_reset;
      t_bb_cond;
      t_events;
      t_summary;
      t_quest;
      print_verdict;
   end
   // the whole run needs about 115 cycles
   initial begin
      repeat (3000) @(posedge core_clk);
      err_total++;
      print_verdict;
   end
endmodule
